// *** inc/sfs_params.svh ***
// Constants of the serial flash command block
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH
`define SFS_CMD_WREN 8'h06
`define SFS_CMD_WRDI 8'h04
`define SFS_CMD_RDSR1 8'h05
`define SFS_CMD_RDSR2 8'h35
`define SFS_CMD_WVOL 8'h50
`define SFS_CMD_WRSR 8'h01
`define SFS_CMD_READ 8'h03
`define SFS_CMD_FAST 8'h0b
`define SFS_CMD_DOUT 8'h3b
`define SFS_CMD_QOUT 8'h6b
`define SFS_CMD_QIO 8'heb
`define SFS_CMD_SECR 8'h48
`define SFS_CMD_PP 8'h02
`define SFS_CMD_SE 8'h20
`define SFS_CMD_BE32 8'h52
`define SFS_CMD_BE64 8'hd8
`define SFS_CMD_CE1 8'hc7
`define SFS_CMD_CE2 8'h60
`define SFS_SR_STATUS_PROTECT_LO 7
`define SFS_SR_STATUS_PROTECT_HI 8
`define SFS_SR_QE 9
`define SFS_SR_CMP 14
`define SFS_SR_WMASK 16'h7ffc
`define SFS_NV_RST 16'h0000
`define SFS_REG_STAT 8'h00
`define SFS_REG_NVSTAT 8'h04
`define SFS_REG_MEMWR 8'h08
`define SFS_CLK_MHZ 40
`define SFS_TW_US 10
`define SFS_PE_US 20
`define SFS_TW_CYC 16'(`SFS_TW_US * `SFS_CLK_MHZ)
`define SFS_PE_CYC 16'(`SFS_PE_US * `SFS_CLK_MHZ)
`endif

// *** inc/sfs_pkg.sv ***
// Types of the serial flash command block
package sfs_pkg;
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic wp_n;
    logic [3:0] io;
  } sfs_pins_s;
  typedef struct packed {
    sfs_pins_s s1;
    sfs_pins_s s2;
  } sfs_sync_s;
  typedef enum logic [5:0] {
    PH_CMD = 6'h01,
    PH_ADDR = 6'h02,
    PH_DUMMY = 6'h04,
    PH_DATA = 6'h08,
    PH_WDATA = 6'h10,
    PH_SKIP = 6'h20
  } sfs_phase_e;
  typedef struct packed {
    sfs_phase_e phase;
    logic [7:0] cmd;
    logic [4:0] cnt;
    logic [23:0] shf;
    logic [23:0] addr;
    logic [7:0] obyte;
    logic [2:0] ocnt;
    logic [2:0] ow;
    logic qin;
    logic [15:0] sr;
    logic [15:0] nv;
    logic [15:0] wval;
    logic write_enable_latch;
    logic busy;
    logic vol_pend;
    logic nv_cyc;
    logic [15:0] tcnt;
    logic cs_d;
    logic sclk_d;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sfs_top_s;
endpackage

// *** verilog/sfs_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for the serial pins
module sfs_sync (
  input logic ref_clk, // System clock
  input logic resetn, // Synchronous reset, active low
  input logic ce, // Clock enable
  input sfs_pkg::sfs_pins_s pin_raw, // Pins from outside
  output sfs_pkg::sfs_pins_s pin_sync // Pins after two flops
);
  sfs_pkg::sfs_sync_s st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.s1 = pin_raw;
      nxt_st.s2 = st_ff.s1;
    end
    if (!resetn) begin
      // Idle levels: select high, clock low, protect pin high
      nxt_st = {2{7'h50}};
    end
  end
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end
  assign pin_sync = st_ff.s2;
endmodule

// *** verilog/sfs_mem.sv ***
`timescale 1ns/1ps
// Byte array holding main and security contents
module sfs_mem (
  input logic ref_clk, // System clock
  input logic we, // Write strobe
  input logic [10:0] widx, // Write index
  input logic [7:0] wd, // Write byte
  input logic [10:0] ridx, // Read index
  output logic [7:0] rd // Read byte
);
  logic [7:0] mem_ff [0:2047];
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_ff[widx] <= wd;
    end
  end
  assign rd = mem_ff[ridx];
endmodule

// *** verilog/sfs_top.sv ***
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Serial flash command decoder with APB access to state and contents
`include "sfs_params.svh"
module sfs_top (
  input logic ref_clk, // 40 MHz clock
  input logic resetn, // Synchronous reset, active low
  input logic ce, // Clock enable, freezes state when low
  input logic psel, // APB select
  input logic penable, // APB enable
  input logic pwrite, // APB direction
  input logic [7:0] paddr, // APB byte address
  input logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input logic cs_n, // Serial select, active low
  input logic sclk, // Serial clock
  input logic wp_n, // Write protect pin, active low
  input logic [3:0] io_in, // Serial lanes in
  output logic [3:0] io_out, // Serial lanes out
  output logic [3:0] io_oe // Serial lane enables
);
  sfs_pkg::sfs_top_s st_ff, nxt_st;
  sfs_pkg::sfs_pins_s pin_raw, pin_s;
  logic rise, fall, cs_up, hw_prot, ok, mem_we, apb_acc;
  logic [7:0] cmd_byte, src_byte, mem_rd;
  logic [15:0] stat, cand, newv;
  logic [10:0] ridx;
  logic [23:0] ashf;

  function automatic logic [3:0] lane_out(input logic [3:0] t, input logic [2:0] w);
    case (w)
      3'h1: lane_out = {2'h0, t[3], 1'h0};
      3'h2: lane_out = {2'h0, t[3:2]};
      default: lane_out = t;
    endcase
  endfunction

  function automatic logic [3:0] lane_oe(input logic [2:0] w);
    case (w)
      3'h1: lane_oe = 4'h2;
      3'h2: lane_oe = 4'h3;
      default: lane_oe = 4'hf;
    endcase
  endfunction

  assign pin_raw = {cs_n, sclk, wp_n, io_in};

  sfs_sync u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .pin_raw(pin_raw),
    .pin_sync(pin_s)
  );

  // Security reads use the upper half, main reads wrap in the lower
  assign ridx = {st_ff.cmd == `SFS_CMD_SECR, st_ff.addr[9:0]};
  assign apb_acc = psel & penable & st_ff.pready;
  assign mem_we = ce & apb_acc & pwrite & (paddr == `SFS_REG_MEMWR);

  sfs_mem u_mem (
    .ref_clk(ref_clk),
    .we(mem_we),
    .widx(pwdata[26:16]),
    .wd(pwdata[7:0]),
    .ridx(ridx),
    .rd(mem_rd)
  );

  always_comb begin
    nxt_st = st_ff;
    rise = ce & ~pin_s.cs_n & pin_s.sclk & ~st_ff.sclk_d;
    fall = ce & ~pin_s.cs_n & ~pin_s.sclk & st_ff.sclk_d;
    cs_up = ce & pin_s.cs_n & ~st_ff.cs_d;
    hw_prot = st_ff.sr[`SFS_SR_STATUS_PROTECT_LO] & ~pin_s.wp_n;
    stat = {st_ff.sr[15:2], st_ff.write_enable_latch, st_ff.busy};
    cmd_byte = {st_ff.shf[6:0], pin_s.io[0]};
    ok = ~st_ff.busy | (cmd_byte == `SFS_CMD_RDSR1) | (cmd_byte == `SFS_CMD_RDSR2);
    cand = {st_ff.sr[15:8], st_ff.shf[7:0]};
    if (st_ff.cnt == 5'h08) begin
      cand[`SFS_SR_CMP] = 1'b0;
      cand[`SFS_SR_QE] = 1'b0;
      cand[`SFS_SR_STATUS_PROTECT_HI] = 1'b0;
    end else begin
      cand = {st_ff.shf[7:0], st_ff.shf[15:8]};
    end
    newv = (cand & `SFS_SR_WMASK) | (st_ff.sr & ~`SFS_SR_WMASK);
    ashf = st_ff.qin ? {st_ff.shf[19:0], pin_s.io} : {st_ff.shf[22:0], pin_s.io[0]};
    if (st_ff.cmd == `SFS_CMD_RDSR1) begin
      src_byte = stat[7:0];
    end else if (st_ff.cmd == `SFS_CMD_RDSR2) begin
      src_byte = stat[15:8];
    end else if (st_ff.cmd == `SFS_CMD_SECR && st_ff.addr[23:10] != 14'h0) begin
      src_byte = 8'hff;
    end else begin
      src_byte = mem_rd;
    end
    if (ce) begin
      nxt_st.cs_d = pin_s.cs_n;
      nxt_st.sclk_d = pin_s.sclk;
      if (st_ff.busy) begin
        if (st_ff.tcnt == 16'h1) begin
          nxt_st.busy = 1'b0;
          nxt_st.write_enable_latch = 1'b0;
          if (st_ff.nv_cyc) begin
            nxt_st.nv = st_ff.wval;
            nxt_st.sr = st_ff.wval;
          end
        end else begin
          nxt_st.tcnt = st_ff.tcnt - 16'h1;
        end
      end
      // APB slave, one wait state
      nxt_st.pready = psel & penable & ~st_ff.pready;
      if (psel & penable & ~st_ff.pready) begin
        nxt_st.pslverr = 1'b0;
        unique case (paddr)
          `SFS_REG_STAT: nxt_st.prdata = {14'h0, st_ff.vol_pend, st_ff.busy, stat};
          `SFS_REG_NVSTAT: nxt_st.prdata = {16'h0, st_ff.nv};
          `SFS_REG_MEMWR: nxt_st.prdata = 32'h0;
          default: begin
            nxt_st.prdata = 32'h0;
            nxt_st.pslverr = 1'b1;
          end
        endcase
      end
    end
    if (pin_s.cs_n) begin
      if (ce) begin
        nxt_st.phase = sfs_pkg::PH_CMD;
        nxt_st.cnt = 5'h0;
        nxt_st.io_oe = 4'h0;
      end
      if (cs_up && st_ff.phase == sfs_pkg::PH_SKIP) begin
        unique case (st_ff.cmd)
          `SFS_CMD_WREN: nxt_st.write_enable_latch = 1'b1;
          `SFS_CMD_WRDI: nxt_st.write_enable_latch = 1'b0;
          `SFS_CMD_WVOL: nxt_st.vol_pend = 1'b1;
          `SFS_CMD_PP, `SFS_CMD_SE, `SFS_CMD_BE32, `SFS_CMD_BE64,
          `SFS_CMD_CE1, `SFS_CMD_CE2: begin
            nxt_st.busy = 1'b1;
            nxt_st.nv_cyc = 1'b0;
            nxt_st.tcnt = `SFS_PE_CYC;
          end
          default: nxt_st.cmd = st_ff.cmd;
        endcase
      end
      if (cs_up && st_ff.phase == sfs_pkg::PH_WDATA) begin
        nxt_st.vol_pend = 1'b0;
        if ((st_ff.cnt == 5'h08 || st_ff.cnt == 5'h10) && !hw_prot) begin
          if (st_ff.vol_pend) begin
            nxt_st.sr = newv;
          end else if (st_ff.write_enable_latch) begin
            nxt_st.busy = 1'b1;
            nxt_st.nv_cyc = 1'b1;
            nxt_st.wval = newv;
            nxt_st.tcnt = `SFS_TW_CYC;
          end
        end
      end
    end else if (rise) begin
      unique case (st_ff.phase)
        sfs_pkg::PH_CMD: begin
          nxt_st.shf = {st_ff.shf[22:0], pin_s.io[0]};
          nxt_st.cnt = st_ff.cnt + 5'h1;
          if (st_ff.cnt == 5'h07) begin
            nxt_st.cnt = 5'h0;
            nxt_st.phase = sfs_pkg::PH_SKIP;
            nxt_st.cmd = ok ? cmd_byte : 8'h00;
            nxt_st.qin = 1'b0;
            nxt_st.ow = 3'h1;
            nxt_st.ocnt = 3'h0;
            if (ok) begin
              unique case (cmd_byte)
                `SFS_CMD_READ, `SFS_CMD_FAST, `SFS_CMD_SECR:
                  nxt_st.phase = sfs_pkg::PH_ADDR;
                `SFS_CMD_DOUT: begin
                  nxt_st.phase = sfs_pkg::PH_ADDR;
                  nxt_st.ow = 3'h2;
                end
                `SFS_CMD_QOUT: begin
                  nxt_st.phase = sfs_pkg::PH_ADDR;
                  nxt_st.ow = 3'h4;
                end
                `SFS_CMD_QIO: begin
                  if (st_ff.sr[`SFS_SR_QE]) begin
                    nxt_st.phase = sfs_pkg::PH_ADDR;
                    nxt_st.qin = 1'b1;
                    nxt_st.ow = 3'h4;
                  end else begin
                    nxt_st.cmd = 8'h00;
                  end
                end
                `SFS_CMD_RDSR1, `SFS_CMD_RDSR2: nxt_st.phase = sfs_pkg::PH_DATA;
                `SFS_CMD_WRSR: nxt_st.phase = sfs_pkg::PH_WDATA;
                `SFS_CMD_WREN, `SFS_CMD_WRDI, `SFS_CMD_WVOL: nxt_st.cmd = cmd_byte;
                `SFS_CMD_PP, `SFS_CMD_SE, `SFS_CMD_BE32, `SFS_CMD_BE64,
                `SFS_CMD_CE1, `SFS_CMD_CE2: begin
                  if (!st_ff.write_enable_latch) begin
                    nxt_st.cmd = 8'h00;
                  end
                end
                default: nxt_st.cmd = 8'h00;
              endcase
            end
          end
        end
        sfs_pkg::PH_ADDR: begin
          nxt_st.shf = ashf;
          nxt_st.cnt = st_ff.cnt + 5'h1;
          if (st_ff.cnt == (st_ff.qin ? 5'h05 : 5'h17)) begin
            nxt_st.addr = ashf;
            nxt_st.cnt = 5'h0;
            if (st_ff.cmd == `SFS_CMD_READ) begin
              nxt_st.phase = sfs_pkg::PH_DATA;
            end else begin
              nxt_st.phase = sfs_pkg::PH_DUMMY;
            end
          end
        end
        sfs_pkg::PH_DUMMY: begin
          // Mode and dummy clocks are counted, their contents unused
          nxt_st.cnt = st_ff.cnt + 5'h1;
          if (st_ff.cnt == (st_ff.qin ? 5'h05 : 5'h07)) begin
            nxt_st.phase = sfs_pkg::PH_DATA;
            nxt_st.cnt = 5'h0;
          end
        end
        sfs_pkg::PH_WDATA: begin
          nxt_st.shf = {st_ff.shf[22:0], pin_s.io[0]};
          if (st_ff.cnt != 5'h1f) begin
            nxt_st.cnt = st_ff.cnt + 5'h1;
          end
        end
        default: nxt_st.cnt = st_ff.cnt;
      endcase
    end else if (fall && st_ff.phase == sfs_pkg::PH_DATA) begin
      if (st_ff.ocnt == 3'h0) begin
        nxt_st.io_out = lane_out(src_byte[7:4], st_ff.ow);
        nxt_st.obyte = src_byte << st_ff.ow;
        nxt_st.ocnt = 3'(4'h8 / {1'b0, st_ff.ow} - 4'h1);
        nxt_st.addr = st_ff.addr + 24'h1;
      end else begin
        nxt_st.io_out = lane_out(st_ff.obyte[7:4], st_ff.ow);
        nxt_st.obyte = st_ff.obyte << st_ff.ow;
        nxt_st.ocnt = st_ff.ocnt - 3'h1;
      end
      nxt_st.io_oe = lane_oe(st_ff.ow);
    end
    if (!resetn) begin
      nxt_st = '0;
      nxt_st.phase = sfs_pkg::PH_CMD;
      nxt_st.ow = 3'h1;
      nxt_st.cs_d = 1'b1;
      nxt_st.nv = `SFS_NV_RST;
      nxt_st.sr = `SFS_NV_RST;
      nxt_st.write_enable_latch = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign io_out = st_ff.io_out;
  assign io_oe = st_ff.io_oe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_wel_set: assert property (cs_up && st_ff.phase == sfs_pkg::PH_SKIP &&
    st_ff.cmd == `SFS_CMD_WREN |=> st_ff.write_enable_latch)
    else $error("write enable did not set latch");
  a_wel_clear: assert property (cs_up && st_ff.phase == sfs_pkg::PH_SKIP &&
    st_ff.cmd == `SFS_CMD_WRDI |=> !st_ff.write_enable_latch)
    else $error("write disable did not clear latch");
  a_cycle_end_wel: assert property (ce && st_ff.busy && st_ff.tcnt == 16'h1 &&
    !(cs_up && st_ff.cmd == `SFS_CMD_WREN) |=> !st_ff.write_enable_latch && !st_ff.busy)
    else $error("latch or busy left set after cycle");
  a_nv_cycle: assert property (cs_up && st_ff.phase == sfs_pkg::PH_WDATA &&
    st_ff.cnt == 5'h10 && !hw_prot && st_ff.write_enable_latch && !st_ff.vol_pend && !st_ff.busy
    |=> st_ff.busy && st_ff.tcnt == `SFS_TW_CYC && st_ff.wval == $past(newv))
    else $error("status write cycle not started");
  a_wsr_length: assert property (cs_up && st_ff.phase == sfs_pkg::PH_WDATA &&
    st_ff.cnt != 5'h08 && st_ff.cnt != 5'h10 && !st_ff.busy
    |=> !st_ff.busy && $stable(st_ff.sr))
    else $error("status write of wrong length executed");
  a_hw_protect: assert property (cs_up && st_ff.phase == sfs_pkg::PH_WDATA &&
    hw_prot && !st_ff.busy |=> !st_ff.busy && $stable(st_ff.sr))
    else $error("status write taken in protected mode");
  a_sr_top_bit: assert property (ce |=> st_ff.sr[15] == $past(st_ff.sr[15]))
    else $error("status bit 15 changed");
  a_one_byte: assert property (cs_up && st_ff.phase == sfs_pkg::PH_WDATA &&
    st_ff.cnt == 5'h08 && !hw_prot && st_ff.vol_pend
    |=> !st_ff.sr[`SFS_SR_CMP] && !st_ff.sr[`SFS_SR_QE] && !st_ff.sr[`SFS_SR_STATUS_PROTECT_HI])
    else $error("one byte write kept upper protect bits");
  a_vol_no_wel: assert property (cs_up && st_ff.phase == sfs_pkg::PH_SKIP &&
    st_ff.cmd == `SFS_CMD_WVOL |=> st_ff.vol_pend && st_ff.write_enable_latch == $past(st_ff.write_enable_latch))
    else $error("volatile enable misbehaved");
  a_read_busy: assert property (rise && st_ff.phase == sfs_pkg::PH_CMD &&
    st_ff.cnt == 5'h07 && st_ff.busy && cmd_byte == `SFS_CMD_READ
    |=> st_ff.phase == sfs_pkg::PH_SKIP && st_ff.cmd == 8'h00 && st_ff.busy)
    else $error("read accepted while busy");
  a_status_out: assert property (fall && st_ff.phase == sfs_pkg::PH_DATA &&
    st_ff.cmd == `SFS_CMD_RDSR1 && st_ff.ocnt == 3'h0
    |=> st_ff.io_oe == 4'h2 && st_ff.io_out[1] == $past(stat[7]))
    else $error("status bit 7 not driven on serial output");
  a_dual_lanes: assert property (fall && st_ff.phase == sfs_pkg::PH_DATA &&
    st_ff.cmd == `SFS_CMD_DOUT && st_ff.ocnt == 3'h0
    |=> st_ff.io_oe == 4'h3 && st_ff.io_out[1:0] == $past(src_byte[7:6]))
    else $error("dual lanes carry wrong bits");
  a_quad_lanes: assert property (fall && st_ff.phase == sfs_pkg::PH_DATA &&
    st_ff.ow == 3'h4 && st_ff.ocnt == 3'h0
    |=> st_ff.io_oe == 4'hf && st_ff.io_out == $past(src_byte[7:4]))
    else $error("quad lanes carry wrong nibble");

  c_status_read: cover property (fall && st_ff.cmd == `SFS_CMD_RDSR2);
  c_nv_write: cover property (st_ff.busy && st_ff.nv_cyc && st_ff.tcnt == 16'h1);
  c_quad_io: cover property (fall && st_ff.cmd == `SFS_CMD_QIO);
  c_apb_error: cover property (st_ff.pready && st_ff.pslverr);
endmodule

// *** tb/sfs_host.sv ***
// Behavioural SPI host model driving select, serial clock and lane 0, or all four lanes in put4
`timescale 1ns/1ps
module sfs_host (
  input wire logic ref_clk, // System clock
  input wire logic [3:0] dev_out, // Device lane values
  input wire logic [3:0] dev_oe, // Device lane enables
  output logic cs_n, // Serial select, active low
  output logic sclk, // Serial clock, still outside frames
  output logic [3:0] io_w // Resolved lane levels
);
  logic [3:0] h_io;
  logic [3:0] h_oe;
  logic flip;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    h_io = 4'h0;
    h_oe = 4'h0;
    flip = 1'b0;
  end
  always @(posedge ref_clk) begin
    flip <= ~flip;
  end
  // Released lanes toggle so a stale level never reads as data
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_w[i] = dev_oe[i] ? dev_out[i] : h_oe[i] ? h_io[i] : flip ^ i[0];
    end
  end
  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic start();
    cs_n <= 1'b0;
    half();
  endtask
  // Bits go out MSB first and are held across the rising edge
  task automatic put(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      h_oe <= 4'h1;
      h_io <= {3'h0, v[i]};
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
    h_oe <= 4'h0;
  endtask
  // Nibbles on all four lanes, lane 3 the high bit, high nibble first
  task automatic put4(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      h_oe <= 4'hf;
      h_io <= v[4 * i +: 4];
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
    h_oe <= 4'h0;
  endtask
  // Sampled at the end of the high phase, well after the device update
  task automatic get(input int ln, output logic [7:0] b);
    for (int k = 0; k < 8 / ln; k++) begin
      half();
      sclk <= 1'b1;
      half();
      if (ln == 1) b = {b[6:0], io_w[1]};
      else if (ln == 2) b = {b[5:0], io_w[1:0]};
      else b = {b[3:0], io_w};
      sclk <= 1'b0;
    end
  endtask
  task automatic stop();
    half();
    cs_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule

// *** tb/test_serial_flash_status_and_read_cmds.sv ***
// Self-checking bench for the serial flash command block
`timescale 1ns/1ps
`include "sfs_params.svh"
module test_serial_flash_status_and_read_cmds;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wp_n = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cs_n;
  logic sclk;
  logic [3:0] io_w;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  int n_fail = 0;
  int checked = 0;
  logic [15:0] sr = 16'h0;
  logic [15:0] nv = 16'h0;
  logic write_enable_latch = 1'b0;
  logic [7:0] mem [2048];
  logic [7:0] rc [4] = '{8'h03, 8'h0b, 8'h3b, 8'h6b};
  int rl [4] = '{1, 1, 2, 4};
  logic [31:0] rd;
  logic er;
  logic [7:0] b;
  int idx;
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  sfs_top i_sfs_top (.ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .wp_n(wp_n),
    .io_in(io_w), .io_out(io_out), .io_oe(io_oe));
  sfs_host i_sfs_host (.ref_clk(ref_clk), .dev_out(io_out), .dev_oe(io_oe), .cs_n(cs_n),
    .sclk(sclk), .io_w(io_w));
  task stop_test();
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  function automatic logic [31:0] st();
    return {16'h0, sr[15:2], write_enable_latch, 1'b0};
  endfunction
  function automatic void upd(input logic [15:0] v, input logic two);
    logic [15:0] m;
    m = `SFS_SR_WMASK;
    if (!two) begin
      m = m & 16'h00ff;
      sr = sr & ~16'h4300;
    end
    sr = (sr & ~m) | (v & m);
  endfunction
  task stat(input logic [31:0] e);
    apb(1'b0, 8'h00, 32'h0);
    chk_reg("stat", e, rd);
  endtask
  task nvst();
    apb(1'b0, 8'h04, 32'h0);
    chk_reg("nvstat", {16'h0, nv}, rd);
  endtask
  task cmd(input logic [7:0] c);
    i_sfs_host.start();
    i_sfs_host.put(c, 8);
    i_sfs_host.stop();
  endtask
  task wrsr(input logic [15:0] v, input int n);
    i_sfs_host.start();
    i_sfs_host.put(8'h01, 8);
    i_sfs_host.put(v, n);
    i_sfs_host.stop();
  endtask
  task rdst(input logic [7:0] c, input logic [7:0] e);
    i_sfs_host.start();
    i_sfs_host.put(c, 8);
    repeat (2) begin
      i_sfs_host.get(1, b);
      chk_byte("status", e, b);
    end
    i_sfs_host.stop();
  endtask
  // Polls the busy flag until the write cycle ends
  task poll(input logic chk1);
    int n;
    n = 0;
    do begin
      i_sfs_host.start();
      i_sfs_host.put(8'h05, 8);
      i_sfs_host.get(1, b);
      i_sfs_host.stop();
      n++;
      if (n == 1 && chk1) chk_byte("busy", 8'h01, {7'h0, b[0]});
    end while (b[0] !== 1'b0 && n < 40);
    chk_byte("idle", 8'h00, {7'h0, b[0]});
  endtask
  task automatic rdmem(input logic [7:0] c, input logic [23:0] a, input int ln,
    input logic dm, input int base, input logic wr);
    logic [7:0] x;
    i_sfs_host.start();
    i_sfs_host.put(c, 8);
    if (c == 8'heb) begin
      i_sfs_host.put4(a, 6);
      i_sfs_host.put4(24'($urandom), 6);
    end else begin
      i_sfs_host.put(a, 24);
      if (dm) i_sfs_host.put($urandom, 8);
    end
    for (int k = 0; k < 4; k++) begin
      i_sfs_host.get(ln, x);
      chk_byte("data", mem[wr ? (base + k) % 1024 : base + k], x);
    end
    i_sfs_host.stop();
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h60ba));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    stat(st());
    nvst();
    apb(1'b0, 8'h0c, 32'h0);
    chk_reg("pslverr", 32'h1, {31'h0, er});
    $display("test reset done");
    cmd(8'h06);
    write_enable_latch = 1'b1;
    stat(st());
    rdst(8'h05, st());
    cmd(8'h04);
    write_enable_latch = 1'b0;
    stat(st());
    wrsr(16'hfc43, 16);
    stat(st());
    $display("test latch done");
    cmd(8'h06);
    wrsr(16'hfc43, 16);
    poll(1'b1);
    upd(16'h43fc, 1'b1);
    nv = sr;
    stat(st());
    nvst();
    rdst(8'h35, sr[15:8]);
    cmd(8'h06);
    wrsr(16'h009c, 8);
    poll(1'b1);
    upd(16'h009c, 1'b0);
    nv = sr;
    stat(st());
    $display("test status write done");
    cmd(8'h50);
    stat(st() | 32'h20000);
    wrsr(16'h0020, 8);
    upd(16'h0020, 1'b0);
    stat(st());
    nvst();
    wrsr(16'h0000, 8);
    stat(st());
    cmd(8'h06);
    wrsr(16'h00ff, 12);
    cmd(8'h04);
    stat(st());
    cmd(8'h50);
    wrsr(16'h0080, 8);
    upd(16'h0080, 1'b0);
    wp_n <= 1'b0;
    cmd(8'h06);
    write_enable_latch = 1'b1;
    wrsr(16'h0000, 8);
    stat(st());
    wp_n <= 1'b1;
    cmd(8'h04);
    write_enable_latch = 1'b0;
    $display("test volatile and protect done");
    for (int k = 0; k < 12; k++) begin
      idx = k < 8 ? (1020 + k) % 1024 : 1285 + k - 8;
      mem[idx] = 8'($urandom);
      apb(1'b1, 8'h08, {5'h0, idx[10:0], 8'h0, mem[idx]});
    end
    for (int i = 0; i < 4; i++) begin
      rdmem(rc[i], 24'(1020 + i), rl[i], i > 0, 1020 + i, 1'b1);
    end
    rdmem(8'h48, 24'h000105, 1, 1'b1, 1285, 1'b0);
    cmd(8'h50);
    wrsr(16'h1002, 16);
    upd(16'h0210, 1'b1);
    stat(st());
    rdmem(8'heb, 24'd1022, 4, 1'b1, 1022, 1'b1);
    cmd(8'h20);
    stat(st());
    cmd(8'h06);
    cmd(8'h20);
    poll(1'b1);
    stat(st());
    $display("test reads done");
    cmd(8'h06);
    wrsr(16'h1000, 16);
    i_sfs_host.start();
    i_sfs_host.put(8'h03, 8);
    i_sfs_host.put(24'h0, 24);
    i_sfs_host.get(1, b);
    chk_reg("io_oe", 32'h0, {28'h0, io_oe});
    i_sfs_host.stop();
    poll(1'b0);
    upd(16'h0010, 1'b1);
    nv = sr;
    stat(st());
    nvst();
    $display("test busy reject done");
    stop_test();
  end
endmodule
